// >>> include/dmct_pkg.sv
// constants and types for the dma channel trigger control block
package dmct_pkg;
  // register byte addresses (low 12 address bits decoded)
  localparam logic [11:0] ADDR_SWTRIG  = 12'h010;
  localparam logic [11:0] ADDR_BUSYCH  = 12'h028;
  localparam logic [11:0] ADDR_PENDING_CHANNELS_REG  = 12'h02C;
  localparam logic [11:0] ADDR_CHID    = 12'h03C;
  localparam logic [11:0] ADDR_CHCTRLA = 12'h040;
  localparam logic [11:0] ADDR_CTRLB   = 12'h044;
  localparam logic [11:0] ADDR_CHSTAT  = 12'h04C;
  // reset values
  localparam logic [31:0] CTRLB_RESET  = 32'h0000_0000;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;
  // channel control b field positions
  localparam int CMD_LSB     = 24;
  localparam int TRIGGER_ACTION_LSB = 22;
  localparam int TRIGGER_SOURCE_SELECT_LSB = 8;
  localparam int LVL_LSB     = 5;
  localparam int EVENT_OUTPUT_ENABLE_BIT    = 4;
  localparam int EVENT_INPUT_ENABLE_BIT    = 3;
  localparam int EVENT_ACTION_SELECT_LSB   = 0;
  // channel control a and status positions
  localparam int ENABLE_BIT  = 1;
  localparam int STAT_PEND   = 0;
  localparam int STAT_BUSY   = 1;
  localparam int STAT_SUSP   = 2;
  // trigger source code that selects no peripheral line
  localparam logic [4:0] TRIGGER_SOURCE_SELECT_NONE = 5'h00;
  // event action encodings
  typedef enum logic [2:0] {
    DMCT_EV_NONE  = 3'b000,          // event inputs ignored
    DMCT_EV_TRIG  = 3'b001,          // normal event-triggered transfer
    DMCT_EV_CTRIG = 3'b010           // conditional transfer on strobe
  } dmct_event_action_select_t;
  // software command encodings
  typedef enum logic [1:0] {
    DMCT_CMD_NONE    = 2'b00,        // no_action_code
    DMCT_CMD_SUSPEND = 2'b01,        // suspend channel
    DMCT_CMD_RESUME  = 2'b10,        // resume channel
    DMCT_CMD_RSVD    = 2'b11         // reserved, no effect
  } dmct_cmd_t;
  // bus slave read sequencing
  typedef enum logic [0:0] {
    DMCT_BUS_IDLE = 1'b0,            // ready for a new transfer
    DMCT_BUS_RDWT = 1'b1             // one wait state on reads
  } dmct_bus_t;
endpackage

// >>> src/dmct_chan.sv
// one dma channel: pending flag, busy flag, suspend and trigger qualification
`timescale 1ns/100ps
`default_nettype none
module dmct_chan (
  input  wire logic       hclk,        // system clock
  input  wire logic       hresetn,     // async reset, active low
  input  wire logic       enabled,     // channel_n_enabled
  input  wire logic [2:0] ev_act,      // event_action_select
  input  wire logic       ev_ie,       // event_input_enable
  input  wire logic       ev_oe,       // event_output_enable
  input  wire logic       trig,        // selected peripheral trigger level
  input  wire logic       ev_edge,     // event arrival, one cycle
  input  wire logic       swtrig,      // software trigger, one cycle
  input  wire logic       cmd_susp,    // suspend command, one cycle
  input  wire logic       cmd_res,     // resume command, one cycle
  input  wire logic       xfer_done,   // engine finished the transfer
  output logic            pend,        // channel_pending_flag
  output logic            busy,        // channel_n_active_bit
  output logic            susp,        // channel suspended
  output logic            xfer_start,  // transfer begins, one cycle
  output logic            ev_ack,      // event acknowledge, one cycle
  output logic            ev_out       // event output, one cycle
);
  logic trig_q;                        // previous trigger level
  logic ev_in;                         // event seen by an enabled input
  logic trig_rise;                     // new peripheral request
  logic set_req;                       // something wants to set pending
  logic start;                         // transfer begins this cycle

  // qualify inputs; the enable gates every event input
  always_comb begin
    ev_in     = ev_edge & ev_ie & enabled;  // [R14]
    trig_rise = trig & ~trig_q & enabled;
    set_req   = 1'b0;
    case (ev_act)
      dmct_pkg::DMCT_EV_TRIG: set_req = ev_in;          // [R1]
      dmct_pkg::DMCT_EV_CTRIG: set_req = ev_in & trig;  // [R5] [R6] [R7]
      dmct_pkg::DMCT_EV_NONE: set_req = trig_rise;      // [R13]
      default: set_req = 1'b0;
    endcase
    // conditional mode waits for software once pending
    start = pend & ~busy & ~susp & enabled &
            ((ev_act == dmct_pkg::DMCT_EV_CTRIG) ? swtrig : 1'b1);  // [R9]
  end

  // trigger history for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) trig_q <= 1'b0;
    else trig_q <= trig;
  end

  // pending flag; a set in the clearing cycle wins, a set while pending is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
    end else if (set_req && (!pend || start)) begin
      pend <= 1'b1;                    // [R3] [R4] [R8]
    end else if (start || !enabled) begin
      pend <= 1'b0;                    // [R15]
    end
  end

  // busy from start until the engine reports completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) busy <= 1'b0;
    else if (start) busy <= 1'b1;
    else if (xfer_done) busy <= 1'b0;
  end

  // suspend state, commands act even while enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) susp <= 1'b0;
    else if (cmd_susp) susp <= 1'b1;   // [R11]
    else if (cmd_res) susp <= 1'b0;    // [R11]
  end

  // strobes: ack does not wait for the transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_ack     <= 1'b0;
      xfer_start <= 1'b0;
      ev_out     <= 1'b0;
    end else begin
      ev_ack     <= ev_in;             // [R2]
      xfer_start <= start;
      ev_out     <= start & ev_oe;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_begin;
    xfer_start ##0 busy;
  endsequence
  a_ack_prompt: assert property (ev_in |=> ev_ack) // [R2]
    else $error("event not acknowledged next cycle");
  a_pend_set: assert property (set_req && !pend |=> pend) // [R3]
    else $error("accepted trigger did not set pending");
  a_trig_lost: assert property (pend && busy && set_req && enabled |=> pend && !xfer_start) // [R4]
    else $error("trigger while pending had an effect");
  a_norm_start: assert property (ev_act == dmct_pkg::DMCT_EV_TRIG && ev_in && !pend
    && !busy && !susp |=> ##1 s_begin) // [R1]
    else $error("normal event did not start a transfer");
  a_cond_cause: assert property (ev_act == dmct_pkg::DMCT_EV_CTRIG && $rose(pend)
    |-> $past(ev_edge) && $past(trig)) // [R5]
    else $error("conditional pending without trigger and event");
  a_cond_hold: assert property (ev_act == dmct_pkg::DMCT_EV_CTRIG && trig && !ev_edge
    && !pend |=> !pend) // [R7]
    else $error("trigger registered without an event");
  a_cond_sw: assert property (ev_act == dmct_pkg::DMCT_EV_CTRIG && xfer_start
    |-> $past(swtrig) && $past(pend)) // [R9]
    else $error("conditional transfer began without software trigger");
  a_start_clr: assert property (start && !set_req |=> !pend ##0 s_begin) // [R15]
    else $error("pending not cleared when transfer began");
  a_susp_cmd: assert property (cmd_susp |=> susp ##1 !xfer_start) // [R11]
    else $error("suspend command not obeyed");
endmodule
`default_nettype wire

// >>> src/dmct_top.sv
// dma channel trigger control with an ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] normal event starts a beat or burst
// [R2] acknowledge event at once, no waiting
// [R3] accepted trigger sets pending flag and bit
// [R4] event while pending is dropped
// [R5] conditional mode needs trigger and event together
// [R6] register trigger only when idle and event
// [R7] held trigger waits for an event
// [R8] both active sets pending flag and bit
// [R9] pending conditional transfer starts on software trigger
// [R10] control b acts on selected channel
// [R11] command field: none, suspend, resume, reserved
// [R12] command field writable while channel enabled
// [R13] trigger action zero: one trigger per block
// [R14] event action select and input enable gating
// [R15] pending clears when its transfer begins
module dmct_top #(
  parameter int NCH   = 4,             // number of channels
  parameter int NTRIG = 32             // peripheral trigger lines
) (
  input  wire logic             hclk,        // system clock
  input  wire logic             hresetn,     // async reset, active low
  input  wire logic             hsel,        // slave select
  input  wire logic [31:0]      haddr,       // byte address
  input  wire logic [1:0]       htrans,      // transfer type
  input  wire logic             hwrite,      // write when high
  input  wire logic [2:0]       hsize,       // transfer size
  input  wire logic [31:0]      hwdata,      // write data
  input  wire logic             hready,      // bus ready
  output logic                  hreadyout,   // slave ready
  output logic [31:0]           hrdata,      // read data
  output logic                  hresp,       // always okay
  input  wire logic [NTRIG-1:0] trig_in,     // peripheral trigger pins
  input  wire logic [NCH-1:0]   ev_in,       // event channel pins
  input  wire logic [NCH-1:0]   xfer_done,   // engine done, same clock
  output logic [NCH-1:0]        xfer_start,  // transfer begin strobes
  output logic [NCH-1:0]        ev_ack,      // event acknowledges
  output logic [NCH-1:0]        ev_out       // channel event outputs
);
  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

  // bus state
  dmct_pkg::dmct_bus_t bus_st;         // read wait sequencer
  logic [11:0]      rd_addr;           // latched read address
  logic [11:0]      wr_addr;           // latched write address
  logic             wr_go;             // write data phase active
  logic             take;              // address phase accepted
  logic [31:0]      rd_val;            // selected read value
  // software-visible state
  logic [CHW-1:0]   chid;              // selected_channel_index
  logic [NCH-1:0]   ch_en;             // channel_n_enabled
  logic [1:0]       trig_action [NCH]; // trigger_action
  logic [4:0]       trig_src    [NCH]; // trigger_source_select
  logic [1:0]       prio_lvl    [NCH]; // priority_level
  logic [2:0]       ev_sel      [NCH]; // event_action_select
  logic [NCH-1:0]   ev_oe;             // event_output_enable
  logic [NCH-1:0]   ev_ie;             // event_input_enable
  logic [NCH-1:0]   swtrig_p;          // software trigger pulses
  logic [NCH-1:0]   susp_p;            // suspend command pulses
  logic [NCH-1:0]   res_p;             // resume command pulses
  // channel state
  logic [NCH-1:0]   pend_ch;           // pending_channels_reg
  logic [NCH-1:0]   busy_ch;           // busy channels
  logic [NCH-1:0]   susp_ch;           // suspended channels
  logic [NCH-1:0]   trig_sel;          // trigger per channel
  // pin synchronisers
  logic [NTRIG-1:0] tr_s1, tr_s2, tr_s3, tr_st;  // trigger sync stages
  logic [NCH-1:0]   ev_s1, ev_s2, ev_s3, ev_st;  // event sync stages
  logic [NCH-1:0]   ev_prev;           // stable event history
  logic [NCH-1:0]   ev_edge;           // event arrival pulses

  // assemble channel control b of one channel
  function automatic logic [31:0] pack_ctrlb(input logic [1:0] ta,
                                             input logic [4:0] ts,
                                             input logic [1:0] lv,
                                             input logic oe,
                                             input logic ie,
                                             input logic [2:0] ea);
    logic [31:0] v;
    v = dmct_pkg::CTRLB_RESET;
    v[dmct_pkg::TRIGGER_ACTION_LSB +: 2] = ta;
    v[dmct_pkg::TRIGGER_SOURCE_SELECT_LSB +: 5] = ts;
    v[dmct_pkg::LVL_LSB +: 2]     = lv;
    v[dmct_pkg::EVENT_OUTPUT_ENABLE_BIT]         = oe;
    v[dmct_pkg::EVENT_INPUT_ENABLE_BIT]         = ie;
    v[dmct_pkg::EVENT_ACTION_SELECT_LSB +: 3]   = ea;
    return v;
  endfunction

  // pick one trigger line, code zero or out of range selects none
  function automatic logic pick_trig(input logic [NTRIG-1:0] t,
                                     input logic [4:0] s);
    logic r;
    r = 1'b0;
    if (s != dmct_pkg::TRIGGER_SOURCE_SELECT_NONE && int'(s) < NTRIG) r = t[s];
    return r;
  endfunction

  // three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tr_s1 <= '0;
      tr_s2 <= '0;
      tr_s3 <= '0;
      tr_st <= '0;
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
      ev_st <= '0;
    end else begin
      tr_s1 <= trig_in;
      tr_s2 <= tr_s1;
      tr_s3 <= tr_s2;
      tr_st <= (tr_s3 & ~(tr_s2 ^ tr_s3)) | (tr_st & (tr_s2 ^ tr_s3));
      ev_s1 <= ev_in;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      ev_st <= (ev_s3 & ~(ev_s2 ^ ev_s3)) | (ev_st & (ev_s2 ^ ev_s3));
    end
  end

  // event edge detection on the filtered level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_prev <= '0;
    else ev_prev <= ev_st;
  end
  assign ev_edge = ev_st & ~ev_prev;

  // address phase acceptance
  assign take = hsel & htrans[1] & hready;

  // bus sequencer: writes zero wait, reads one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st    <= dmct_pkg::DMCT_BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= dmct_pkg::RDATA_ZERO;
      hresp     <= 1'b0;
      rd_addr   <= '0;
      wr_addr   <= '0;
      wr_go     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (bus_st)
        dmct_pkg::DMCT_BUS_IDLE: begin
          wr_go <= take & hwrite;
          if (take) begin
            wr_addr <= haddr[11:0];
            rd_addr <= haddr[11:0];
          end
          if (take && !hwrite) begin
            // read waits so a preceding write is committed first
            bus_st    <= dmct_pkg::DMCT_BUS_RDWT;
            hreadyout <= 1'b0;
          end
        end
        dmct_pkg::DMCT_BUS_RDWT: begin
          wr_go     <= 1'b0;
          hrdata    <= rd_val;
          hreadyout <= 1'b1;
          bus_st    <= dmct_pkg::DMCT_BUS_IDLE;
        end
        default: bus_st <= dmct_pkg::DMCT_BUS_IDLE;
      endcase
    end
  end

  // read decode; unmapped reads return zero
  always_comb begin
    rd_val = dmct_pkg::RDATA_ZERO;
    if (rd_addr == dmct_pkg::ADDR_CTRLB) begin
      rd_val = pack_ctrlb(trig_action[chid], trig_src[chid], prio_lvl[chid],
                          ev_oe[chid], ev_ie[chid], ev_sel[chid]);  // [R10]
    end else if (rd_addr == dmct_pkg::ADDR_CHID) begin
      rd_val[CHW-1:0] = chid;
    end else if (rd_addr == dmct_pkg::ADDR_CHCTRLA) begin
      rd_val[dmct_pkg::ENABLE_BIT] = ch_en[chid];
    end else if (rd_addr == dmct_pkg::ADDR_CHSTAT) begin
      rd_val[dmct_pkg::STAT_PEND] = pend_ch[chid];  // [R3]
      rd_val[dmct_pkg::STAT_BUSY] = busy_ch[chid];
      rd_val[dmct_pkg::STAT_SUSP] = susp_ch[chid];
    end else if (rd_addr == dmct_pkg::ADDR_PENDING_CHANNELS_REG) begin
      rd_val[NCH-1:0] = pend_ch;       // [R3] [R8]
    end else if (rd_addr == dmct_pkg::ADDR_BUSYCH) begin
      rd_val[NCH-1:0] = busy_ch;
    end
  end

  // channel index and enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chid  <= '0;
      ch_en <= '0;
    end else if (wr_go) begin
      if (wr_addr == dmct_pkg::ADDR_CHID) begin
        chid <= hwdata[CHW-1:0];
      end else if (wr_addr == dmct_pkg::ADDR_CHCTRLA) begin
        ch_en[chid] <= hwdata[dmct_pkg::ENABLE_BIT];
      end
    end
  end

  // channel control b fields, locked while the selected channel is enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        trig_action[i] <= '0;
        trig_src[i]    <= '0;
        prio_lvl[i]    <= '0;
        ev_sel[i]      <= '0;
      end
      ev_oe <= '0;
      ev_ie <= '0;
    end else if (wr_go && wr_addr == dmct_pkg::ADDR_CTRLB && !ch_en[chid]) begin
      trig_action[chid] <= hwdata[dmct_pkg::TRIGGER_ACTION_LSB +: 2];  // [R10] [R13]
      trig_src[chid]    <= hwdata[dmct_pkg::TRIGGER_SOURCE_SELECT_LSB +: 5];
      prio_lvl[chid]    <= hwdata[dmct_pkg::LVL_LSB +: 2];
      ev_oe[chid]       <= hwdata[dmct_pkg::EVENT_OUTPUT_ENABLE_BIT];
      ev_ie[chid]       <= hwdata[dmct_pkg::EVENT_INPUT_ENABLE_BIT];          // [R14]
      ev_sel[chid]      <= hwdata[dmct_pkg::EVENT_ACTION_SELECT_LSB +: 3];    // [R14]
    end
  end

  // command and software trigger pulses; commands ignore the lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_p   <= '0;
      res_p    <= '0;
      swtrig_p <= '0;
    end else begin
      susp_p   <= '0;
      res_p    <= '0;
      swtrig_p <= '0;
      if (wr_go && wr_addr == dmct_pkg::ADDR_CTRLB) begin
        case (dmct_pkg::dmct_cmd_t'(hwdata[dmct_pkg::CMD_LSB +: 2]))  // [R12]
          dmct_pkg::DMCT_CMD_SUSPEND: susp_p[chid] <= 1'b1;           // [R11]
          dmct_pkg::DMCT_CMD_RESUME: res_p[chid] <= 1'b1;             // [R11]
          default: susp_p <= '0;
        endcase
      end
      if (wr_go && wr_addr == dmct_pkg::ADDR_SWTRIG) begin
        swtrig_p <= hwdata[NCH-1:0];
      end
    end
  end

  // per-channel trigger selection and channel instances
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign trig_sel[g] = pick_trig(tr_st, trig_src[g]);
    dmct_chan u_chan (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .enabled    (ch_en[g]),
      .ev_act     (ev_sel[g]),
      .ev_ie      (ev_ie[g]),
      .ev_oe      (ev_oe[g]),
      .trig       (trig_sel[g]),
      .ev_edge    (ev_edge[g]),
      .swtrig     (swtrig_p[g]),
      .cmd_susp   (susp_p[g]),
      .cmd_res    (res_p[g]),
      .xfer_done  (xfer_done[g]),
      .pend       (pend_ch[g]),
      .busy       (busy_ch[g]),
      .susp       (susp_ch[g]),
      .xfer_start (xfer_start[g]),
      .ev_ack     (ev_ack[g]),
      .ev_out     (ev_out[g])
    );
  end

  // unused bus inputs: sizes are whole words only
  logic unused_ok;
  assign unused_ok = ^{haddr[31:12], hsize, htrans[0]};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_lock_ctrlb: assert property (wr_go && wr_addr == dmct_pkg::ADDR_CTRLB && ch_en[chid]
    |=> $stable(ev_sel[chid])) // [R12]
    else $error("control b changed while channel enabled");
  a_cmd_susp: assert property (wr_go && wr_addr == dmct_pkg::ADDR_CTRLB
    && hwdata[dmct_pkg::CMD_LSB +: 2] == 2'b01 |=> ##1 susp_ch[$past(chid, 2)]) // [R11]
    else $error("suspend command lost");
endmodule
`default_nettype wire

// >>> dv/dmct_evsrc.sv
// event system and peripheral trigger model facing the channel block
`timescale 1ns/100ps
`default_nettype none
module dmct_evsrc (
  input  wire logic        hclk,      // system clock
  input  wire logic [3:0]  ev_req,    // one-cycle request per event line
  input  wire logic [1:0]  ev_len,    // extra high cycles of an event
  input  wire logic [31:0] trig_req,  // requested trigger levels
  output logic      [3:0]  ev_in,     // event levels to the block
  output logic      [31:0] trig_in    // trigger levels to the block
);
  logic [2:0] hold [4];               // remaining high cycles per line
  initial begin
    ev_in = 4'h0;
    trig_in = 32'h0000_0000;
    for (int i = 0; i < 4; i++) hold[i] = 3'd0;
  end
  // an event is a short high level that always falls back low, so each is a fresh edge
  always @(posedge hclk) begin
    trig_in <= trig_req;
    for (int i = 0; i < 4; i++) begin
      if (ev_req[i]) begin
        hold[i] <= 3'd2 + {1'b0, ev_len};
        ev_in[i] <= 1'b1;
      end else if (hold[i] != 3'd0) begin
        hold[i] <= hold[i] - 3'd1;
        ev_in[i] <= (hold[i] != 3'd1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the dma channel trigger control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int EV_SETTLE = 16;      // covers pin sync, ack and fall of the level
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        hreadyout, hresp;
  logic [31:0] trig_in, trig_req;
  logic [3:0]  ev_in, ev_req, xfer_done, xfer_start, ev_ack, ev_out;
  logic [1:0]  ev_len;
  logic [7:0]  seed;                  // lfsr state
  logic [31:0] starts, acks, wv;      // pulse counts on channel 0, scratch
  logic [31:0] outs;                  // event output pulses on channel 0
  int          bad_count, cmp_count;
  dmct_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .trig_in(trig_in),
    .ev_in(ev_in), .xfer_done(xfer_done), .xfer_start(xfer_start), .ev_ack(ev_ack),
    .ev_out(ev_out));
  dmct_evsrc u_src (.hclk(hclk), .ev_req(ev_req), .ev_len(ev_len), .trig_req(trig_req),
    .ev_in(ev_in), .trig_in(trig_in));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // count strobes of channel 0 as they happen
  always @(posedge hclk) begin
    starts <= starts + {31'h0, xfer_start[0]};
    acks <= acks + {31'h0, ev_ack[0]};
    outs <= outs + {31'h0, ev_out[0]};
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic report_and_stop();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait for hready at a rising edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // one single ahb-lite word transfer
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  // one event on a line, with a random high time
  task automatic ev(input int c);
    seed = lfsr(seed);
    ev_len <= seed[1:0];
    ev_req <= 4'h1 << c;
    @(posedge hclk);
    ev_req <= 4'h0;
    repeat (EV_SETTLE) @(posedge hclk);
  endtask
  task automatic done0();
    xfer_done <= 4'h1;
    @(posedge hclk);
    xfer_done <= 4'h0;
    repeat (4) @(posedge hclk);
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0;
    hwdata = 32'h0000_0000; trig_req = 32'h0000_0000; ev_req = 4'h0; ev_len = 2'd0;
    xfer_done = 4'h0; seed = 8'd82; starts = 32'h0000_0000; acks = 32'h0000_0000;
    outs = 32'h0000_0000;
    bad_count = 0; cmp_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // register reset value and unmapped space
    rchk(dmct_pkg::ADDR_CTRLB, dmct_pkg::CTRLB_RESET);
    rchk(12'h100, dmct_pkg::RDATA_ZERO);
    $display("test reset and map done");
    // random fields on disabled channel 2, reserved bits 7 and 13-21 read back zero
    wr(dmct_pkg::ADDR_CHID, 32'h0000_0002);
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 4; b++) begin
        seed = lfsr(seed);
        wv[b*8 +: 8] = seed;
      end
      wv = wv & 32'h003F_FFFF;
      wr(dmct_pkg::ADDR_CTRLB, wv);
      rchk(dmct_pkg::ADDR_CTRLB, wv & 32'h0000_1F7F);
    end
    wr(dmct_pkg::ADDR_CHID, 32'h0000_0001);
    rchk(dmct_pkg::ADDR_CTRLB, dmct_pkg::CTRLB_RESET);
    $display("test random fields done");
    // normal event action on channel 0
    wr(dmct_pkg::ADDR_CHID, 32'h0000_0000);
    wr(dmct_pkg::ADDR_CTRLB, 32'h0000_0009);
    wr(dmct_pkg::ADDR_CHCTRLA, 32'h0000_0002);
    ev(0);
    chk(starts, 32'h0000_0001);
    rchk(dmct_pkg::ADDR_PENDING_CHANNELS_REG, 32'h0000_0000);
    ev(0);
    rchk(dmct_pkg::ADDR_PENDING_CHANNELS_REG, 32'h0000_0001);
    rchk(dmct_pkg::ADDR_CHSTAT, 32'h0000_0003);
    ev(0);
    chk(acks, 32'h0000_0003);
    done0();
    chk(starts, 32'h0000_0002);
    done0();
    chk(starts, 32'h0000_0002);
    $display("test normal events done");
    // commands act while enabled, other fields stay
    wr(dmct_pkg::ADDR_CTRLB, 32'h0100_0002);
    rchk(dmct_pkg::ADDR_CTRLB, 32'h0000_0009);
    rchk(dmct_pkg::ADDR_CHSTAT, 32'h0000_0004);
    wr(dmct_pkg::ADDR_CTRLB, 32'h0300_0000);
    rchk(dmct_pkg::ADDR_CHSTAT, 32'h0000_0004);
    wr(dmct_pkg::ADDR_CTRLB, 32'h0200_0000);
    rchk(dmct_pkg::ADDR_CHSTAT, 32'h0000_0000);
    $display("test commands done");
    // input enable off: events are not taken
    wr(dmct_pkg::ADDR_CHCTRLA, 32'h0000_0000);
    wr(dmct_pkg::ADDR_CTRLB, 32'h0000_0001);
    wr(dmct_pkg::ADDR_CHCTRLA, 32'h0000_0002);
    ev(0);
    chk(acks, 32'h0000_0003);
    chk(starts, 32'h0000_0002);
    $display("test input enable done");
    // conditional strobe on trigger line 5
    wr(dmct_pkg::ADDR_CHCTRLA, 32'h0000_0000);
    wr(dmct_pkg::ADDR_CTRLB, 32'h0000_051A);
    wr(dmct_pkg::ADDR_CHCTRLA, 32'h0000_0002);
    trig_req <= 32'h0000_0020;
    repeat (EV_SETTLE) @(posedge hclk);
    rchk(dmct_pkg::ADDR_PENDING_CHANNELS_REG, 32'h0000_0000);
    ev(0);
    rchk(dmct_pkg::ADDR_PENDING_CHANNELS_REG, 32'h0000_0001);
    chk(starts, 32'h0000_0002);
    wr(dmct_pkg::ADDR_SWTRIG, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    chk(starts, 32'h0000_0003);
    chk(outs, 32'h0000_0001);
    rchk(dmct_pkg::ADDR_PENDING_CHANNELS_REG, 32'h0000_0000);
    trig_req <= 32'h0000_0000;
    $display("test conditional strobe done");
    report_and_stop();
  end
endmodule
`default_nettype wire
